// *** rtl/eeprom_ctl_pkg.sv ***
// Purpose: Constants and types for the data EEPROM row write control block
// Assumes: 8-bit data space, 64-byte EEPROM page at 00h-3Fh, 10 MHz mclk
// Notes:   Function list below; each line names one behaviour by tag
//
// Function
// - Armed writes latch row address and data
// - Only captured row visible while armed
// - Arming clears eight row latches, markers
// - Row cycle writes only loaded bytes
// - Arming bit self-clears after row cycle
// - Start needs enable and arming set
// - Start bit begins row programming, self-clears
// - Armed, not started: accept row writes
// - Row is address bits 5..3 equal
// - Disarm before start discards latched row
// - Busy flag set during programming
// - Access while busy aborted, cycle completes
// - No programming with enable clear
// - Standby bit disables EEPROM, low power
// - Cells start erased at FFh
// - Control writes ignored while busy
// - Unarmed write programs single byte
// - Access needs EEPROM page selected
// - Stop instruction disables EEPROM
package eeprom_ctl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR       = 8'hEA;  // Control register
  localparam logic [7:0] CTRL_RESET      = 8'h00;  // Control reset value
  localparam logic [7:0] PAGE_LAST       = 8'h3F;  // Top of paged window
  localparam int         BIT_ENABLE      = 0;      // Program enable
  localparam int         BIT_BUSY        = 1;      // Busy flag (read only)
  localparam int         BIT_ARM         = 2;      // Row mode arming
  localparam int         BIT_START       = 3;      // Row start
  localparam int         BIT_STANDBY     = 6;      // Standby
  localparam int         BANK_EE_BIT     = 0;      // EEPROM page bit of bank select
  localparam logic [7:0] ERASED          = 8'hFF;  // Virgin cell value
  localparam int         ROW_BYTES       = 8;      // Bytes per row
  localparam int         EE_BYTES        = 64;     // Page size

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int         CLK_HZ          = 10_000_000;  // mclk rate
  localparam int         PROG_TIME_US    = 5000;        // Default cell write time
  localparam int         PROG_CYCLES     = PROG_TIME_US * (CLK_HZ / 1_000_000);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_BYTE, ST_ROW} prog_state_t;

  // CPU data space access
  typedef struct packed {
    logic       rd;    // Read strobe
    logic       wr;    // Write strobe
    logic [7:0] addr;  // Data space address
    logic [7:0] wdata; // Write data
  } cpu_req_t;

endpackage : eeprom_ctl_pkg

// *** rtl/prog_timer.sv ***
// Purpose: Programming cycle timer; runs a fixed count after a start pulse
// Assumes: Start only while idle
// Notes:   Count is a parameter so simulation can shorten it
`timescale 1ns/1ps
module prog_timer
  import eeprom_ctl_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Control
  input  wire logic start,
  output logic      running,
  output logic      done
);

  logic [31:0] cnt_q;  // Cycles left

  // Count down; busy from start until the count expires
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0000_0000;
    end else if (start && cnt_q == 32'h0000_0000) begin
      cnt_q <= 32'(CYCLES);
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  assign running = (cnt_q != 32'h0000_0000);
  assign done    = (cnt_q == 32'h0000_0001);

endmodule : prog_timer

// *** rtl/eeprom_row_write_control.sv ***
// Purpose: Data EEPROM control: byte and row programming, busy, standby
// Assumes: CPU strobes synchronous to mclk; one access per strobe cycle
// Notes:   Cell array is modelled as a register array holding 64 bytes
`timescale 1ns/1ps
module eeprom_row_write_control
  import eeprom_ctl_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // CPU data space access
  input  wire cpu_req_t   req,
  output logic [7:0]      rdata,
  output logic            rdata_valid,
  // System
  input  wire logic [7:0] bank_select_reg,
  input  wire logic       stop_exec,
  // Status
  output logic            program_busy_flag,
  output logic            ee_powered
);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]  cells_q [EE_BYTES];   // Non-volatile cells
  logic [7:0]  row_data_q [ROW_BYTES]; // Volatile row latches
  logic [7:0]  row_load_q;           // Loaded markers
  logic [2:0]  row_addr_q;           // Captured row
  logic        row_captured_q;       // Row address latched
  logic        program_enable_q;     // Enable bit
  logic        row_mode_arm_q;       // Arming bit
  logic        row_program_start_q;  // Start bit
  logic        eeprom_standby_q;     // Standby bit
  logic        stopped_q;            // Stop seen
  logic [5:0]  byte_addr_q;          // Byte mode target
  logic [7:0]  byte_data_q;          // Byte mode data
  prog_state_t state_q;              // Programming state
  logic        t_start;              // Timer kick
  logic        t_done;               // Timer expiry
  logic        t_run;                // Timer running

  // Decode helper: EEPROM window hit
  function automatic logic ee_hit(input logic [7:0] a);
    ee_hit = (a <= PAGE_LAST);
  endfunction : ee_hit

  // ************************************************************
  // Access qualification
  // ************************************************************
  logic ee_ok;       // Array usable
  logic ee_wr;       // Accepted cell write
  logic ee_rd;       // Accepted cell read
  logic ctrl_wr;     // Accepted control write
  logic other_row;   // Aim outside captured row

  // Page select, standby, stop and busy gate every cell access
  assign ee_ok     = bank_select_reg[BANK_EE_BIT] && !eeprom_standby_q && !stopped_q && !program_busy_flag;
  assign other_row = row_captured_q && (req.addr[5:3] != row_addr_q);
  assign ee_wr     = req.wr && ee_hit(req.addr) && ee_ok && program_enable_q;
  assign ee_rd     = req.rd && ee_hit(req.addr) && ee_ok && !other_row;
  assign ctrl_wr   = req.wr && (req.addr == CTRL_ADDR) && !program_busy_flag;
  assign program_busy_flag = t_run;
  assign ee_powered        = !eeprom_standby_q && !stopped_q;

  // Start accepted on this write; needs enable and arming already set and now
  logic row_go;
  assign row_go = ctrl_wr && req.wdata[BIT_START] && program_enable_q && row_mode_arm_q
                  && req.wdata[BIT_ARM] && req.wdata[BIT_ENABLE] && !eeprom_standby_q
                  && !stopped_q;

  // ************************************************************
  // Stop latch: cleared only by reset (wake path resets chip)
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stopped_q <= 1'b0;
    end else if (stop_exec) begin
      stopped_q <= 1'b1;
    end
  end

  // ************************************************************
  // Control register bits
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      program_enable_q    <= CTRL_RESET[BIT_ENABLE];
      row_mode_arm_q      <= CTRL_RESET[BIT_ARM];
      row_program_start_q <= CTRL_RESET[BIT_START];
      eeprom_standby_q    <= CTRL_RESET[BIT_STANDBY];
    end else if (t_done && state_q == ST_ROW) begin
      // End of row cycle clears both row bits
      row_mode_arm_q      <= 1'b0;
      row_program_start_q <= 1'b0;
    end else if (ctrl_wr) begin
      program_enable_q <= req.wdata[BIT_ENABLE];
      eeprom_standby_q <= req.wdata[BIT_STANDBY];
      row_mode_arm_q   <= req.wdata[BIT_ARM];
      // Bit follows the real cycle start, so a refused start leaves it clear
      row_program_start_q <= row_go;
    end
  end

  // ************************************************************
  // Row latches
  // ************************************************************
  logic arm_rise;
  assign arm_rise = ctrl_wr && req.wdata[BIT_ARM] && !row_mode_arm_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      row_load_q     <= 8'h00;
      row_addr_q     <= 3'h0;
      row_captured_q <= 1'b0;
      for (int i = 0; i < ROW_BYTES; i++) begin
        row_data_q[i] <= 8'h00;
      end
    end else if (arm_rise) begin
      row_load_q     <= 8'h00;
      row_captured_q <= 1'b0;
      for (int i = 0; i < ROW_BYTES; i++) begin
        row_data_q[i] <= 8'h00;
      end
    end else if ((ctrl_wr && !req.wdata[BIT_ARM]) || (t_done && state_q == ST_ROW)) begin
      row_load_q     <= 8'h00;  // Discard on disarm or finish
      row_captured_q <= 1'b0;
    end else if (row_mode_arm_q && !row_program_start_q && ee_wr && !other_row) begin
      // Writes fill latches only; first one fixes the row
      row_captured_q                <= 1'b1;
      row_addr_q                    <= req.addr[5:3];
      row_data_q[req.addr[2:0]]     <= req.wdata;
      row_load_q[req.addr[2:0]]     <= 1'b1;
    end
  end

  // ************************************************************
  // Programming sequencer
  // ************************************************************
  assign t_start = (state_q == ST_IDLE) && (row_go || (ee_wr && !row_mode_arm_q));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_IDLE;
      byte_addr_q <= 6'h00;
      byte_data_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (row_go) begin
            state_q <= ST_ROW;
          end else if (ee_wr && !row_mode_arm_q) begin
            state_q     <= ST_BYTE;
            byte_addr_q <= req.addr[5:0];
            byte_data_q <= req.wdata;
          end
        end
        default: begin
          if (t_done) begin
            state_q <= ST_IDLE;  // Cycle completes regardless of access
          end
        end
      endcase
    end
  end

  // Cell array: committed at cycle end; erased after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        cells_q[i] <= ERASED;
      end
    end else if (t_done && state_q == ST_BYTE) begin
      cells_q[byte_addr_q] <= byte_data_q;
    end else if (t_done && state_q == ST_ROW) begin
      for (int i = 0; i < ROW_BYTES; i++) begin
        if (row_load_q[i]) begin
          cells_q[{row_addr_q, 3'(i)}] <= row_data_q[i];
        end
      end
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      if (req.rd && req.addr == CTRL_ADDR) begin
        rdata       <= {6'h00, program_busy_flag, 1'b0};
        rdata_valid <= 1'b1;
      end else if (ee_rd) begin
        rdata       <= cells_q[req.addr[5:0]];
        rdata_valid <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Timer
  // ************************************************************
  prog_timer #(
    .CYCLES (PROG_CNT)
  ) u_timer (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .start   (t_start),
    .running (t_run),
    .done    (t_done)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  a_start_needs_arm: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(row_program_start_q) |-> $past(row_mode_arm_q) && $past(program_enable_q))
    else $error("start set without arm and enable");

  a_busy_after_go: assert property (@(posedge mclk) disable iff (!rst_b)
    t_start |=> program_busy_flag)
    else $error("busy not raised at cycle start");

  a_arm_self_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (t_done && state_q == ST_ROW) |=> !row_mode_arm_q && !row_program_start_q)
    else $error("row bits not cleared at cycle end");

  a_ctrl_frozen_busy: assert property (@(posedge mclk) disable iff (!rst_b)
    (program_busy_flag && !t_done) |=> $stable(program_enable_q) && $stable(eeprom_standby_q))
    else $error("control changed while busy");

  a_no_write_disabled: assert property (@(posedge mclk) disable iff (!rst_b)
    (!program_enable_q && state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("cycle started with enable clear");

  a_arm_clears_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    arm_rise |=> row_load_q == 8'h00)
    else $error("latches not cleared on arm");

  a_standby_no_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (eeprom_standby_q && req.rd && ee_hit(req.addr)) |=> !rdata_valid)
    else $error("read answered in standby");

  a_busy_no_start: assert property (@(posedge mclk) disable iff (!rst_b)
    program_busy_flag |-> !t_start)
    else $error("new cycle while busy");

endmodule : eeprom_row_write_control

// *** sim/tb_eeprom_row_write_control.sv ***
// Purpose: Self-checking bench for the data EEPROM row write control block
// Assumes: Programming count shortened to 8 cycles; bank page bit set unless a test clears it
// Notes:   Inputs change on rising mclk by non-blocking assignment
`timescale 1ns/1ps
module tb_eeprom_row_write_control
  import eeprom_ctl_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int P = 8;          // Short programming count for simulation
  logic       mclk = 1'b0;       // 10 MHz clock
  logic       rst_b;             // Async reset, active low
  cpu_req_t   req;               // CPU access
  logic [7:0] rdata;             // Read data
  logic       rdata_valid;       // Read answer pulse
  logic [7:0] bank_select_reg;   // Bank select level
  logic       stop_exec;         // Stop instruction
  logic       program_busy_flag; // Busy status
  logic       ee_powered;        // Power status
  int         miscompares = 0;   // Mismatch count
  int         compares = 0;      // Comparison count
  int         cycles = 0;        // Timeout counter
  // Half period of 50 ns
  always #50 mclk = ~mclk;
  eeprom_row_write_control #(.PROG_CNT(P)) u_dut (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .req               (req),
    .rdata             (rdata),
    .rdata_valid       (rdata_valid),
    .bank_select_reg   (bank_select_reg),
    .stop_exec         (stop_exec),
    .program_busy_flag (program_busy_flag),
    .ee_powered        (ee_powered)
  );
  // ************************************************************
  // Tasks
  // ************************************************************
  // Verdict; the only exit of the run
  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Byte compare with message
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One write strobe, released at the taking edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : wr
  // One read; answer looked at in the cycle after the taking edge
  task rd(input logic [7:0] a, input logic [7:0] e, input logic ok);
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    compares++;
    if (rdata_valid !== ok || (ok && rdata !== e)) begin
      miscompares++;
      $display("[FAIL] %0t read %h valid %b data %h", $time, a, rdata_valid, rdata);
    end
  endtask : rd
  // Did a cycle start, and did busy last exactly P cycles
  task prog(input logic exp);
    int n;
    int w;
    n = 0;
    w = 0;
    #1;
    // Busy may rise on the taking edge or the next one
    while (program_busy_flag !== 1'b1 && w < 3) begin
      @(posedge mclk);
      #1;
      w++;
    end
    while (program_busy_flag === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h00, n != 0}, {7'h00, exp}, "cycle start");
    if (exp) chk(8'(n), 8'(P), "busy length");
  endtask : prog
  // End-of-test line
  task done(input string t);
    $display("test %s done at %0t", t, $time);
  endtask : done
  // Timeout: the whole run needs well under 3000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    int i;
    req = '0;
    bank_select_reg = 8'h01;
    stop_exec = 1'b0;
    rst_b = 1'b0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset state and erased cells
    rd(CTRL_ADDR, CTRL_RESET, 1'b1);
    chk({7'h00, ee_powered}, 8'h01, "powered after reset");
    for (i = 0; i < EE_BYTES; i += 9) rd(8'(i), ERASED, 1'b1);
    done("reset");
    // Enable clear: no cycle
    wr(8'h08, 8'h5A);
    prog(1'b0);
    rd(8'h08, ERASED, 1'b1);
    // Single byte write with exact busy length
    wr(CTRL_ADDR, 8'h01);
    wr(8'h08, 8'h5A);
    prog(1'b1);
    rd(8'h08, 8'h5A, 1'b1);
    done("byte");
    // Accesses during busy are dropped; control write ignored
    wr(8'h10, 8'hC3);
    rd(CTRL_ADDR, 8'h02, 1'b1);
    wr(CTRL_ADDR, 8'h00);
    rd(8'h10, 8'h00, 1'b0);
    wr(8'h12, 8'h66);
    repeat (P) @(posedge mclk);
    rd(8'h10, 8'hC3, 1'b1);
    rd(8'h12, ERASED, 1'b1);
    wr(8'h13, 8'h5A);
    prog(1'b1);
    done("busy");
    // Row write of three bytes; other row ignored
    wr(CTRL_ADDR, 8'h05);
    wr(8'h18, 8'h11);
    wr(8'h1A, 8'h22);
    wr(8'h1B, 8'h33);
    wr(8'h20, 8'h44);
    wr(CTRL_ADDR, 8'h0D);
    prog(1'b1);
    rd(8'h18, 8'h11, 1'b1);
    rd(8'h19, ERASED, 1'b1);
    rd(8'h1A, 8'h22, 1'b1);
    rd(8'h1B, 8'h33, 1'b1);
    rd(8'h20, ERASED, 1'b1);
    // Arm bit gone after the row cycle: plain write programs at once
    wr(8'h1C, 8'h77);
    prog(1'b1);
    rd(8'h1C, 8'h77, 1'b1);
    // Start without arm, and start without enable
    wr(CTRL_ADDR, 8'h09);
    prog(1'b0);
    wr(CTRL_ADDR, 8'h04);
    wr(CTRL_ADDR, 8'h0D);
    prog(1'b0);
    done("row");
    // Disarm discards; re-arm clears latches and markers
    wr(CTRL_ADDR, 8'h05);
    wr(8'h00, 8'hAA);
    wr(CTRL_ADDR, 8'h01);
    prog(1'b0);
    wr(CTRL_ADDR, 8'h05);
    wr(8'h01, 8'hBB);
    wr(CTRL_ADDR, 8'h0D);
    prog(1'b1);
    rd(8'h00, ERASED, 1'b1);
    rd(8'h01, 8'hBB, 1'b1);
    done("discard");
    // Page not selected: no access
    @(posedge mclk);
    bank_select_reg <= 8'h00;
    wr(8'h30, 8'h55);
    prog(1'b0);
    rd(8'h30, 8'h00, 1'b0);
    @(posedge mclk);
    bank_select_reg <= 8'h01;
    rd(8'h30, ERASED, 1'b1);
    done("bank");
    // Standby, then back on
    wr(CTRL_ADDR, 8'h41);
    @(posedge mclk);
    #1;
    chk({7'h00, ee_powered}, 8'h00, "standby power");
    rd(8'h08, 8'h00, 1'b0);
    wr(CTRL_ADDR, 8'h01);
    rd(8'h08, 8'h5A, 1'b1);
    // Stop instruction latches the array off
    @(posedge mclk);
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    #1;
    chk({7'h00, ee_powered}, 8'h00, "stop power");
    rd(8'h08, 8'h00, 1'b0);
    done("power");
    conclude();
  end
endmodule : tb_eeprom_row_write_control
